// ### rtl/rcc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcc_regs.svh"

module rcc_top
  import rcc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [5:0] reg_addr_in,
  input wire logic [23:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [23:0] reg_rdata_out,
  // converter samples from the respiration amplifier
  input wire logic signed [15:0] adc_sample_in,
  input wire logic adc_valid_in,
  // drive network
  output logic resp_drive_p_out,
  output logic resp_drive_n_out,
  output logic [1:0] drive_amplitude_out,
  output logic ext_cap_mode_out,
  output logic amp_bypass_out,
  // path switches, one-hot
  output logic [2:0] lead_select_out,
  output logic [2:0] ext_pair_select_out,
  output logic ext_to_ecg_out,
  // sync capable io pin
  output logic sync_capable_io_pin_out,
  output logic sync_capable_io_pin_oe_out,
  // filtered impedance
  output logic [23:0] resp_result_out,
  output logic resp_result_valid_out
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [23:0] channel_control;
  logic [23:0] respiration_control;

  // software writes on the register port
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      channel_control <= `RCC_RESET_REG;
      respiration_control <= `RCC_RESET_REG;
    end else if (reg_write_in) begin
      if (reg_addr_in == `RCC_ADDR_CHANNEL_CONTROL) begin
        channel_control <= reg_wdata_in;
      end
      if (reg_addr_in == `RCC_ADDR_RESP_CONTROL) begin
        respiration_control <= reg_wdata_in;
      end
    end
  end

  // field views
  logic resp_enable;
  logic high_perf_select;
  logic alt_carrier_select;
  logic ext_sync_output_enable;
  logic [1:0] carrier_freq_code;
  rcc_path_t path_sel;
  rcc_ext_pair_t pair_sel;

  assign resp_enable = respiration_control[`RCC_RC_ENABLE];
  assign high_perf_select = channel_control[`RCC_CC_HIGH_PERF];
  assign alt_carrier_select = respiration_control[`RCC_RC_ALT_CARRIER];
  assign ext_sync_output_enable = respiration_control[`RCC_RC_EXT_SYNC_OUT];
  assign carrier_freq_code = respiration_control[`RCC_RC_FREQ_LSB +: 2];
  assign path_sel = rcc_path_t'(respiration_control[`RCC_RC_PATH_LSB +: 2]);
  assign pair_sel = rcc_ext_pair_t'(respiration_control[`RCC_RC_EXT_PAIR_LSB +: 2]);

  // ----------------------------------------------------------------------
  // frequency decode
  // ----------------------------------------------------------------------
  // half period in clocks, rounded to nearest; the 20 MHz clock cannot hit
  // every frequency exactly, the worst error is well under half a percent
  function automatic rcc_half_t half_of(input int unsigned f_hz);
    int unsigned q;
    q = (`RCC_CLK_HZ + f_hz) / (2 * f_hz);
    return q[8:0];
  endfunction : half_of

  // shared decode for the drive and the sync pin; the sync table differs
  // only in the alternate-clear row and in code 01 of high performance
  function automatic rcc_half_t carrier_half(input logic alt, input logic hp,
                                              input logic [1:0] code, input logic for_sync);
    rcc_half_t h;
    h = half_of(`RCC_F_56K);
    if (!alt) begin
      if (for_sync) begin
        h = half_of(`RCC_F_64K);
      end else begin
        unique case (code)
          2'b00: h = half_of(`RCC_F_56K);
          2'b01: h = half_of(`RCC_F_54K);
          2'b10: h = half_of(`RCC_F_52K);
          2'b11: h = half_of(`RCC_F_50K);
        endcase
      end
    end else if (hp) begin
      unique case (code)
        2'b00: h = half_of(`RCC_F_64K);
        2'b01: h = for_sync ? half_of(`RCC_F_56K) : half_of(`RCC_F_56K9);
        2'b10: h = half_of(`RCC_F_51K2);
        2'b11: h = half_of(`RCC_F_46K5);
      endcase
    end else begin
      unique case (code)
        2'b00: h = half_of(`RCC_F_32K);
        2'b01: h = half_of(`RCC_F_28K);
        2'b10: h = half_of(`RCC_F_25K5);
        2'b11: h = half_of(`RCC_F_23K);
      endcase
    end
    return h;
  endfunction : carrier_half

  rcc_half_t drive_half;
  rcc_half_t sync_half;

  assign drive_half = carrier_half(alt_carrier_select, high_perf_select, carrier_freq_code,
                                   1'b0);
  assign sync_half = carrier_half(alt_carrier_select, high_perf_select, carrier_freq_code,
                                  1'b1);

  // ----------------------------------------------------------------------
  // carrier generators
  // ----------------------------------------------------------------------
  logic drive_level;
  logic sync_level;

  rcc_carrier_gen u_drive_gen (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(resp_enable),
    .half_in(drive_half),
    .level_out(drive_level)
  );

  // the sync copy runs from its own divider so its table can differ
  rcc_carrier_gen u_sync_gen (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(resp_enable && ext_sync_output_enable),
    .half_in(sync_half),
    .level_out(sync_level)
  );

  // drive pair and sync pin, registered so no decode glitch escapes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      resp_drive_p_out <= 1'b0;
      resp_drive_n_out <= 1'b0;
      sync_capable_io_pin_out <= 1'b0;
      sync_capable_io_pin_oe_out <= 1'b0;
    end else begin
      resp_drive_p_out <= resp_enable && drive_level;
      resp_drive_n_out <= resp_enable && !drive_level;
      sync_capable_io_pin_out <= sync_level;
      sync_capable_io_pin_oe_out <= resp_enable && ext_sync_output_enable;
    end
  end

  // ----------------------------------------------------------------------
  // path and analog switches
  // ----------------------------------------------------------------------
  // one-hot switches; a single path field makes two paths impossible
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lead_select_out <= 3'b000;
      ext_pair_select_out <= 3'b000;
      ext_to_ecg_out <= 1'b0;
    end else begin
      lead_select_out <= 3'b000;
      ext_pair_select_out <= 3'b000;
      ext_to_ecg_out <= respiration_control[`RCC_RC_EXT_TO_ECG];
      if (resp_enable) begin
        unique case (path_sel)
          RCC_PATH_LEAD_I: lead_select_out <= 3'b001;
          RCC_PATH_LEAD_II: lead_select_out <= 3'b010;
          RCC_PATH_LEAD_III: lead_select_out <= 3'b100;
          RCC_PATH_EXTERNAL: begin
            // external pair is taken from respiration only when not lent to ecg
            if (!respiration_control[`RCC_RC_EXT_TO_ECG]) begin
              unique case (pair_sel)
                RCC_PAIR_LA_RA: ext_pair_select_out <= 3'b001;
                RCC_PAIR_LL_RA: ext_pair_select_out <= 3'b010;
                RCC_PAIR_LL_LA: ext_pair_select_out <= 3'b100;
                RCC_PAIR_NONE: ext_pair_select_out <= 3'b000;
              endcase
            end
          end
        endcase
      end
    end
  end

  // amplitude, capacitor mode and amplifier bypass straight from the register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      drive_amplitude_out <= 2'b00;
      ext_cap_mode_out <= 1'b0;
      amp_bypass_out <= 1'b0;
    end else begin
      drive_amplitude_out <= respiration_control[`RCC_RC_AMPL_LSB +: 2];
      ext_cap_mode_out <= respiration_control[`RCC_RC_EXT_CAP];
      amp_bypass_out <= respiration_control[`RCC_RC_AMP_BYPASS];
    end
  end

  // ----------------------------------------------------------------------
  // synchronous demodulation and low-pass
  // ----------------------------------------------------------------------
  // the chain has no mode other than impedance: no field reroutes it to ecg
  logic signed [23:0] demod;
  logic signed [23:0] lpf;

  assign demod = drive_level ? 24'(adc_sample_in) : -24'(adc_sample_in);

  // first-order iir; the envelope and peak search are left to the host
  always_ff @(posedge clk_in) begin
    if (reset_in || !resp_enable) begin
      lpf <= `RCC_RESET_RESULT;
      resp_result_valid_out <= 1'b0;
    end else begin
      resp_result_valid_out <= adc_valid_in;
      if (adc_valid_in) begin
        lpf <= lpf + ((demod - lpf) >>> `RCC_LPF_SHIFT);
      end
    end
  end

  assign resp_result_out = lpf;

  // ----------------------------------------------------------------------
  // register read back
  // ----------------------------------------------------------------------
  // read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 24'h00_0000;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        `RCC_ADDR_CHANNEL_CONTROL: reg_rdata_out <= channel_control;
        `RCC_ADDR_RESP_CONTROL: reg_rdata_out <= respiration_control;
        `RCC_ADDR_RESP_RESULT: reg_rdata_out <= lpf;
        `RCC_ADDR_RESP_STATUS: reg_rdata_out <= {21'h0_0000, sync_level, drive_level,
                                                resp_enable};
        default: reg_rdata_out <= 24'h00_0000;
      endcase
    end
  end

endmodule : rcc_top

`default_nettype wire

// ### pkg/rcc_regs.svh
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RCC_ADDR_CHANNEL_CONTROL 6'h01
`define RCC_ADDR_RESP_CONTROL 6'h03
`define RCC_ADDR_RESP_RESULT 6'h04
`define RCC_ADDR_RESP_STATUS 6'h05

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RCC_CC_HIGH_PERF 3
`define RCC_RC_ENABLE 0
`define RCC_RC_PATH_LSB 1
`define RCC_RC_EXT_PAIR_LSB 3
`define RCC_RC_EXT_TO_ECG 5
`define RCC_RC_ALT_CARRIER 6
`define RCC_RC_EXT_SYNC_OUT 7
`define RCC_RC_FREQ_LSB 8
`define RCC_RC_AMPL_LSB 10
`define RCC_RC_EXT_CAP 12
`define RCC_RC_AMP_BYPASS 14

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RCC_RESET_REG 24'h00_0000
`define RCC_RESET_RESULT 24'h00_0000

// ----------------------------------------------------------------------
// timing: clock rate and carrier frequencies in hertz
// ----------------------------------------------------------------------
`define RCC_CLK_HZ 20000000
`define RCC_F_64K 64000
`define RCC_F_56K 56000
`define RCC_F_54K 54000
`define RCC_F_52K 52000
`define RCC_F_50K 50000
`define RCC_F_56K9 56900
`define RCC_F_51K2 51200
`define RCC_F_46K5 46500
`define RCC_F_32K 32000
`define RCC_F_28K 28000
`define RCC_F_25K5 25500
`define RCC_F_23K 23000

// low-pass smoothing shift of the demodulated impedance
`define RCC_LPF_SHIFT 6

`endif

// ### pkg/rcc_pkg.sv
`default_nettype none

package rcc_pkg;

  // measurement path choices
  typedef enum logic [1:0] {
    RCC_PATH_LEAD_I,
    RCC_PATH_LEAD_II,
    RCC_PATH_LEAD_III,
    RCC_PATH_EXTERNAL
  } rcc_path_t;

  // dedicated external input pair choices
  typedef enum logic [1:0] {
    RCC_PAIR_LA_RA,
    RCC_PAIR_LL_RA,
    RCC_PAIR_LL_LA,
    RCC_PAIR_NONE
  } rcc_ext_pair_t;

  typedef logic [8:0] rcc_half_t;

endpackage : rcc_pkg

`default_nettype wire

// ### rtl/rcc_carrier_gen.sv
`timescale 1ns/1ps
`default_nettype none

module rcc_carrier_gen
  import rcc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // control
  input wire logic enable_in,
  input wire rcc_half_t half_in,
  // carrier
  output logic level_out
);

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  rcc_half_t count;
  rcc_half_t active_half;

  // new divisor loaded at the falling edge that closes a full period, and on every edge while in reset or off
  always_ff @(posedge clk_in) begin
    if (reset_in || !enable_in) begin
      count <= '0;
      level_out <= 1'b0;
      active_half <= half_in;
    end else if (count >= active_half - 9'd1) begin
      count <= '0;
      level_out <= !level_out;
      if (level_out) begin
        active_half <= half_in;
      end
    end else begin
      count <= count + 9'd1;
    end
  end

endmodule : rcc_carrier_gen

`default_nettype wire

// ### verif/rcc_chk.sv
`timescale 1ns/1ps
`default_nettype none

module rcc_chk (
  // clock, reset and register port
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [23:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic adc_valid_in,
  // design outputs
  input wire logic resp_drive_p_out,
  input wire logic resp_drive_n_out,
  input wire logic ext_cap_mode_out,
  input wire logic [1:0] drive_amplitude_out,
  input wire logic amp_bypass_out,
  input wire logic [2:0] lead_select_out,
  input wire logic [2:0] ext_pair_select_out,
  input wire logic ext_to_ecg_out,
  input wire logic sync_capable_io_pin_oe_out,
  input wire logic resp_result_valid_out
);
  logic [23:0] ctl;
  logic [9:0] hcnt;

  // shadow of the control word, same edge as the design takes it
  always_ff @(posedge clk_in) begin
    if (reset_in) ctl <= 24'h00_0000;
    else if (reg_write_in && reg_addr_in == 6'h03) ctl <= reg_wdata_in;
  end

  // cycles since the drive last moved; cleared while off so a restart is not a long phase
  always_ff @(posedge clk_in) begin
    if (reset_in || !ctl[0] || $changed(resp_drive_p_out)) hcnt <= 10'h000;
    else if (hcnt != 10'h3ff) hcnt <= hcnt + 10'h001;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // a falling drive edge while the carrier keeps running
  sequence s_fall_on;
    $fell(resp_drive_p_out) && ctl[0] && $past(ctl[0]);
  endsequence

  a_half_min: assert property (s_fall_on |-> hcnt >= 10'h096)
    else $error("drive phase shorter than any carrier half period");
  a_half_max: assert property (ctl[0] |-> hcnt <= 10'h1c2)
    else $error("drive phase longer than any carrier half period");
  // the two drive legs are complements while on and the n leg is low while off
  a_drive_pair: assert property (resp_drive_n_out == ($past(ctl[0]) && !resp_drive_p_out))
    else $error("drive pair not complementary");
  a_cap_mode: assert property (ext_cap_mode_out == $past(ctl[12]))
    else $error("capacitor mode output does not follow its bit");
  a_amp_bypass: assert property (amp_bypass_out == $past(ctl[14]))
    else $error("bypass output does not follow its bit");
  a_drive_level: assert property (drive_amplitude_out == $past(ctl[11:10]))
    else $error("amplitude output does not follow its field");
  a_path_single: assert property ($onehot0({lead_select_out, ext_pair_select_out}))
    else $error("more than one measurement path closed");
  a_lead_match: assert property (lead_select_out != 3'b000 |->
    lead_select_out == 3'b001 << $past(ctl[2:1]))
    else $error("lead switch does not match path field");
  a_ecg_loan: assert property (ext_to_ecg_out |-> ext_pair_select_out == 3'b000)
    else $error("external pair closed while lent to ecg");
  a_sync_oe: assert property (sync_capable_io_pin_oe_out == $past(ctl[7] && ctl[0]))
    else $error("sync pin enable does not follow its bit");
  a_sample_ack: assert property (resp_result_valid_out == $past(adc_valid_in && ctl[0]))
    else $error("result valid not one cycle after a sample");
endmodule : rcc_chk

bind rcc_top rcc_chk u_chk (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
  .adc_valid_in, .resp_drive_p_out, .resp_drive_n_out, .ext_cap_mode_out,
  .drive_amplitude_out, .amp_bypass_out, .lead_select_out,
  .ext_pair_select_out, .ext_to_ecg_out, .sync_capable_io_pin_oe_out, .resp_result_valid_out);

`default_nettype wire

// ### verif/rcc_far.sv
`timescale 1ns/1ps
`default_nettype none

module rcc_far (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // carrier on the electrodes and response size
  input wire logic drive_in,
  input wire logic signed [15:0] level_in,
  // amplified samples
  output logic signed [15:0] sample_out,
  output logic valid_out
);
  logic [3:0] tick;

  // sensed voltage in phase with the drive, one sample every 16 clocks;
  // between samples the data toggles so a stale value is never mistaken
  always_ff @(posedge clk_in) begin
    tick <= reset_in ? 4'h0 : tick + 4'h1;
    valid_out <= !reset_in && tick == 4'h0;
    if (!reset_in && tick == 4'h0) sample_out <= drive_in ? level_in : -level_in;
    else sample_out <= ~sample_out;
  end
endmodule : rcc_far

`default_nettype wire

// ### verif/tb_respiration_carrier_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_respiration_carrier_control;
  // half periods: no alt, alt high perf, alt low power
  localparam logic [9:0] HALF [12] = '{10'h0b3, 10'h0b9, 10'h0c0, 10'h0c8, 10'h09c, 10'h0b0,
    10'h0c3, 10'h0d7, 10'h139, 10'h165, 10'h188, 10'h1b3};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [23:0] wdata = 24'h00_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic signed [15:0] lvl = 16'h0000;
  logic signed [15:0] smp;
  logic sv, dp, dn, ab, ecm, ecg, sy, soe, rv;
  logic [1:0] am;
  logic [2:0] ls, ps;
  logic [23:0] rdata, res;
  int fail_count = 0;
  int comparisons = 0;

  initial forever #25 clk_in = ~clk_in;

  rcc_top DUT (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .adc_sample_in(smp),
    .adc_valid_in(sv), .resp_drive_p_out(dp), .resp_drive_n_out(dn), .drive_amplitude_out(am),
    .ext_cap_mode_out(ecm), .amp_bypass_out(ab), .lead_select_out(ls), .ext_pair_select_out(ps),
    .ext_to_ecg_out(ecg), .sync_capable_io_pin_out(sy), .sync_capable_io_pin_oe_out(soe),
    .resp_result_out(res), .resp_result_valid_out(rv));

  rcc_far u_far (.clk_in(clk_in), .reset_in(reset_in), .drive_in(dp), .level_in(lvl),
    .sample_out(smp), .valid_out(sv));

  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one strobe, then a quiet edge so back to back calls never clash
  task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, input logic [23:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
    chk("rdata", rdata, e);
  endtask : rd_reg

  // half period of the drive or sync pin, taken after a full period has passed
  task automatic half(input logic s, output logic [23:0] n);
    logic v;
    int k;
    k = 0;
    n = 0;
    v = s ? sy : dp;
    while (k < 4) begin
      @(posedge clk_in);
      n++;
      if ((s ? sy : dp) !== v) begin
        v = ~v;
        k++;
        if (k < 4) n = 0;
      end
    end
  endtask : half

  function automatic logic [23:0] exp_half(input logic a, h, s, input logic [1:0] c);
    if (!a) return s ? 24'h00_009c : 24'(HALF[c]);
    if (!h) return 24'(HALF[8 + c]);
    return (s && c == 2'b01) ? 24'h00_00b3 : 24'(HALF[4 + c]);
  endfunction : exp_half

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // watchdog at about three times the longest expected run, kept under the cycle budget
  initial begin
    repeat (90000) @(posedge clk_in);
    fail_count++;
    test_done;
  end

  initial begin
    logic [23:0] n, d;
    d = $urandom(32'h56a1);
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rd_reg(6'h03, 24'h00_0000);
    rd_reg(6'h01, 24'h00_0000);
    rd_reg(6'h05, 24'h00_0000);
    rd_reg(6'h3f, 24'h00_0000);
    wr_reg(6'h04, 24'h00_1234);
    rd_reg(6'h04, 24'h00_0000);
    $display("test registers done");
    // every code in every mode, sync copy on
    for (int i = 0; i < 16; i++) begin
      wr_reg(6'h01, {20'h0_0000, i[2], 3'b000});
      wr_reg(6'h03, {14'h0000, i[1:0], 1'b1, i[3], 6'h01});
      half(1'b0, n);
      chk("drive half", n, exp_half(i[3], i[2], 1'b0, i[1:0]));
      half(1'b1, n);
      chk("sync half", n, exp_half(i[3], i[2], 1'b1, i[1:0]));
      chk("sync oe", soe, 24'h00_0001);
    end
    $display("test carrier done");
    for (int i = 0; i < 20; i++) begin
      d = ($urandom & 24'h00_5c3e) | 24'h00_0001;
      wr_reg(6'h03, d);
      rd_reg(6'h03, d);
      chk("amplitude", am, d[11:10]);
      chk("bypass", ab, d[14]);
      chk("cap mode", ecm, d[12]);
      chk("leads", ls, d[2:1] != 2'b11 ? 3'b001 << d[2:1] : 3'b000);
      chk("pairs", ps,
        d[2:1] == 2'b11 && d[4:3] != 2'b11 && !d[5] ? 3'b001 << d[4:3] : 3'b000);
      chk("ecg loan", ecg, d[5]);
      chk("sync oe", soe, 24'h00_0000);
    end
    $display("test paths done");
    lvl <= 16'(1000 + $urandom % 7000);
    wr_reg(6'h03, 24'h00_0001);
    repeat (4000) @(posedge clk_in);
    // in-phase drive settles the host-visible value just below the sensed level
    chk("result level", res > 24'(lvl >>> 1) && res <= 24'(lvl), 24'h00_0001);
    wr_reg(6'h03, 24'h00_0000);
    repeat (10) @(posedge clk_in);
    chk("result off", res, 24'h00_0000);
    chk("drive p off", dp, 24'h00_0000);
    chk("drive n off", dn, 24'h00_0000);
    rd_reg(6'h05, 24'h00_0000);
    chk("valid off", rv, 24'h00_0000);
    $display("test samples done");
    test_done;
  end
endmodule : tb_respiration_carrier_control

`default_nettype wire
